// ===== hdl/shift_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module shift_clock_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [15:0] reload,
  // One pulse every reload+1 cycles
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } div_t;
  div_t d_reg;
  div_t d_next;

  always_comb begin
    d_next = d_reg;
    d_next.tick = 1'b0;
    if (!run) begin
      d_next.cnt = reload;
    end else if (d_reg.cnt == 16'h0000) begin
      d_next.cnt = reload;
      d_next.tick = 1'b1;
    end else begin
      d_next.cnt = d_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  assign tick = d_reg.tick;
endmodule
`default_nettype wire

// ===== hdl/ssp_pkg.sv
package ssp_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TB = 8'h04;
  localparam logic [7:0] OFS_RB = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0C;
  // ----------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------
  localparam int EN_POS = 15;
  localparam int MASTER_SEL_POS = 14;
  localparam int BUSY_POS = 12;
  localparam int BAUD_ERR_POS = 11;
  localparam int PHASE_ERR_POS = 10;
  localparam int RECV_ERR_POS = 9;
  localparam int XMIT_ERR_POS = 8;
  localparam int POLARITY_POS = 6;
  localparam int PHASE_POS = 5;
  localparam int HEADING_POS = 4;
  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] BAUD_RESET = 16'h0003;
  localparam logic [15:0] CFG_WMASK = 16'hCF7F;
  localparam logic [15:0] STAT_WMASK = 16'hCF00;
  localparam logic [19:0] PER_MAX = 20'hFFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } eng_state_t;
endpackage

// ===== hdl/sync_serial_shift_engine.sv
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Enable bit 15 allows transfers and maps control accesses to status view
// - Bit 14 selects slave (external clock) or master (drives clock out)
// - Bit 12 shows a transfer in progress; hardware owns it
// - Bit 11 flags slave clock period off by more than factor 2 or 0.5
// - Phase error flagged when input data changes around the sampling edge
// - Bit 9 flags reception completed before receive buffer was read
// - Bit 8 flags slave transfer starting with transmit buffer not reloaded
// - Bits 3:0 show the shift counter, updated each shifted bit
// - Old enable value decides whether a write hits config or status
// - Transmit buffer right-aligned; bits beyond width ignored
// - Receive buffer right-aligned; bits above width invalid
// - One shift register sends and receives the same number of bits
// - Buffer moves to empty shift register; master starts, slave awaits clock
// - Transfer start sets busy and pulses transmit request
// - After 2 to 16 bits, shift register goes to receive buffer, receive request
// - Busy clears with receive buffer load when transmit buffer empty
// - Heading bit: 0 least significant first, 1 most significant first
// - One clock edge shifts out, the other latches in; phase picks which
// - Polarity sets idle clock level and the leading edge direction
// - Phase 0 shifts on leading, latches trailing; phase 1 the reverse
// - Width field plus one gives transfer bits; zero is reserved
// - Per-error enable bits decide whether each error is checked
module sync_serial_shift_engine (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // AXI4-Lite write address and data
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Shift clock pin
  input wire logic RECEIVED_SHIFT_CLOCK,
  output logic GENERATED_SHIFT_CLOCK,
  output logic GENERATED_SHIFT_CLOCK_OE,
  // Data pins
  input wire logic MASTER_OUT_SLAVE_IN_PIN_I,
  output logic MASTER_OUT_SLAVE_IN_PIN_O,
  output logic MASTER_OUT_SLAVE_IN_PIN_OE,
  input wire logic MASTER_IN_SLAVE_OUT_PIN_I,
  output logic MASTER_IN_SLAVE_OUT_PIN_O,
  output logic MASTER_IN_SLAVE_OUT_PIN_OE,
  // Request lines
  output logic TRANSMIT_IRQ_LINE,
  output logic RECEIVE_IRQ_LINE
);
  typedef struct packed {
    logic en;
    logic ms;
    logic [11:0] cfg;
    logic be;
    logic pe;
    logic re;
    logic te;
    logic [15:0] tb;
    logic tb_full;
    logic [15:0] rb;
    logic rb_full;
    logic [15:0] baud;
    logic [15:0] sr;
    logic [4:0] cnt;
    ssp_pkg::eng_state_t st;
    logic sclk;
    logic tx;
    logic sclk_prev;
    logic rx_prev;
    logic pe_win;
    logic [19:0] per;
    logic per_ok;
    logic transmit_irq_line;
    logic receive_irq_line;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t r;
  state_t n;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [2:0] pins_s;
  logic sclk_s, mosi_s, miso_s, rx_s, tick;
  logic po, ph, hb, ren, pen, ben, ten, busy;
  logic [3:0] bm;
  logic [4:0] w, cnt_n;
  logic edge_s, lead, trail, latch, shft, done, proc, wr, tb_wr, rb_rd;
  logic [15:0] ld_val, sr_sh, sr_f, rb_val, m, stat_v, cfg_v, ctrl_v, cm, ctrl_w;
  logic [19:0] exp_h;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  sync_stage2 #(.W(3)) u_pins (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .d({RECEIVED_SHIFT_CLOCK, MASTER_OUT_SLAVE_IN_PIN_I, MASTER_IN_SLAVE_OUT_PIN_I}),
    .q(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[0];

  shift_clock_divider u_div (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .run(r.en && r.ms && busy),
    .reload(r.baud),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Decode of configuration and serial edges
  // ----------------------------------------------------------------
  assign po = r.cfg[ssp_pkg::POLARITY_POS];
  assign ph = r.cfg[ssp_pkg::PHASE_POS];
  assign hb = r.cfg[ssp_pkg::HEADING_POS];
  assign ben = r.cfg[ssp_pkg::BAUD_ERR_POS];
  assign pen = r.cfg[ssp_pkg::PHASE_ERR_POS];
  assign ren = r.cfg[ssp_pkg::RECV_ERR_POS];
  assign ten = r.cfg[ssp_pkg::XMIT_ERR_POS];
  assign bm = r.cfg[3:0];
  assign w = {1'b0, bm} + 5'h01;
  assign busy = (r.st == ssp_pkg::ST_RUN);
  assign rx_s = r.ms ? miso_s : mosi_s;
  // Master edges come from its own divider, slave edges from the pin
  assign edge_s = r.ms ? tick : (sclk_s != r.sclk_prev);
  assign lead = edge_s && ((r.ms ? r.sclk : r.sclk_prev) == po);
  assign trail = edge_s && !lead;
  assign latch = ph ? lead : trail;
  assign shft = ph ? trail : lead;
  // Left-justify for MSB first so the out bit is always at one end
  assign ld_val = hb ? (r.tb << (4'hF - bm)) : r.tb;
  assign sr_sh = hb ? {r.sr[14:0], rx_s} : {rx_s, r.sr[15:1]};
  assign cnt_n = latch ? r.cnt + 5'h01 : r.cnt;
  assign done = trail && (cnt_n == w);
  assign sr_f = latch ? sr_sh : r.sr;
  assign rb_val = hb ? sr_f : (sr_f >> (4'hF - bm));
  assign exp_h = {4'h0, r.baud} + 20'h00001;
  assign proc = r.en && (busy || (!r.ms && edge_s && !(r.st == ssp_pkg::ST_IDLE && r.tb_full)));

  // ----------------------------------------------------------------
  // Register views and bus decode
  // ----------------------------------------------------------------
  assign stat_v = {r.en, r.ms, 1'b0, busy, r.be, r.pe, r.re, r.te, 4'h0, r.cnt[3:0]};
  assign cfg_v = {r.en, r.ms, 2'b00, r.cfg};
  assign ctrl_v = r.en ? stat_v : cfg_v;
  assign m = {{8{r.wstrb[1]}}, {8{r.wstrb[0]}}};
  // Reserved, busy and count bits are masked off, so they cannot be written
  assign cm = (r.en ? ssp_pkg::STAT_WMASK : ssp_pkg::CFG_WMASK) & m;
  assign ctrl_w = (ctrl_v & ~cm) | (r.wdata & cm);
  assign wr = r.aw_ok && r.w_ok && !r.bvalid;
  assign tb_wr = wr && (r.aw_addr == ssp_pkg::OFS_TB);
  assign rb_rd = ARVALID && !r.rvalid && (ARADDR == ssp_pkg::OFS_RB);

  always_comb begin
    n = r;
    n.transmit_irq_line = 1'b0;
    n.receive_irq_line = 1'b0;
    n.pe_win = 1'b0;
    n.sclk_prev = sclk_s;
    n.rx_prev = rx_s;
    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    if (AWVALID && !r.aw_ok) begin
      n.aw_ok = 1'b1;
      n.aw_addr = AWADDR;
    end
    if (WVALID && !r.w_ok) begin
      n.w_ok = 1'b1;
      n.wdata = WDATA[15:0];
      n.wstrb = WSTRB[1:0];
    end
    if (r.bvalid && BREADY) begin
      n.bvalid = 1'b0;
    end
    if (wr) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = ssp_pkg::RESP_OKAY;
      case (r.aw_addr)
        ssp_pkg::OFS_CTRL: begin
          n.en = ctrl_w[ssp_pkg::EN_POS];
          n.ms = ctrl_w[ssp_pkg::MASTER_SEL_POS];
          if (r.en) begin
            {n.be, n.pe, n.re, n.te} = ctrl_w[11:8];
          end else begin
            n.cfg = ctrl_w[11:0];
          end
        end
        ssp_pkg::OFS_TB: begin
          n.tb = (r.tb & ~m) | (r.wdata & m);
          n.tb_full = 1'b1;
        end
        ssp_pkg::OFS_BAUD: n.baud = (r.baud & ~m) | (r.wdata & m);
        ssp_pkg::OFS_RB: n.bresp = ssp_pkg::RESP_OKAY;
        default: n.bresp = ssp_pkg::RESP_SLVERR;
      endcase
    end
    if (r.rvalid && RREADY) begin
      n.rvalid = 1'b0;
    end
    if (ARVALID && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = ssp_pkg::RESP_OKAY;
      n.rdata = 16'h0000;
      case (ARADDR)
        ssp_pkg::OFS_CTRL: n.rdata = ctrl_v;
        ssp_pkg::OFS_TB: n.rdata = r.tb;
        ssp_pkg::OFS_RB: begin
          n.rdata = r.rb;
          n.rb_full = 1'b0;
        end
        ssp_pkg::OFS_BAUD: n.rdata = r.baud;
        default: n.rresp = ssp_pkg::RESP_SLVERR;
      endcase
    end
    // ----------------------------------------------------------------
    // Transfer sequencing
    // ----------------------------------------------------------------
    if (!r.en) begin
      // Disabled: park the clock at its idle level
      n.st = ssp_pkg::ST_IDLE;
      // Follows the polarity being written, so enabling shows no stray edge
      n.sclk = n.cfg[ssp_pkg::POLARITY_POS];
      n.per_ok = 1'b0;
    end else begin
      if (busy && r.per != ssp_pkg::PER_MAX) begin
        n.per = r.per + 20'h00001;
      end
      case (r.st)
        ssp_pkg::ST_IDLE: begin
          n.per_ok = 1'b0;
          if (r.tb_full) begin
            n.sr = ld_val;
            n.tx = hb ? ld_val[15] : ld_val[0];
            n.tb_full = tb_wr;
            n.cnt = 5'h00;
            n.st = r.ms ? ssp_pkg::ST_RUN : ssp_pkg::ST_WAIT;
            n.transmit_irq_line = r.ms;
          end else if (!r.ms && edge_s) begin
            n.st = ssp_pkg::ST_RUN;
            n.transmit_irq_line = 1'b1;
            n.cnt = 5'h00;
            if (ten) begin
              n.te = 1'b1;
            end
          end
        end
        ssp_pkg::ST_WAIT: begin
          if (r.ms || edge_s) begin
            n.st = ssp_pkg::ST_RUN;
            n.transmit_irq_line = 1'b1;
          end
        end
        ssp_pkg::ST_RUN: n.st = ssp_pkg::ST_RUN;
        default: n.st = ssp_pkg::ST_IDLE;
      endcase
    end
    if (proc) begin
      if (r.ms && tick) begin
        n.sclk = !r.sclk;
      end
      if (shft) begin
        n.tx = hb ? r.sr[15] : r.sr[0];
      end
      if (latch) begin
        n.sr = sr_sh;
        n.cnt = cnt_n;
        n.pe_win = 1'b1;
      end
      // Data moving at the latch edge or just after it
      if ((latch || r.pe_win) && pen && rx_s != r.rx_prev) begin
        n.pe = 1'b1;
      end
      if (lead && !r.ms) begin
        n.per = 20'h00000;
        n.per_ok = 1'b1;
        if (r.per_ok && ben && (r.per > (exp_h << 2) || r.per < exp_h)) begin
          n.be = 1'b1;
        end
      end
      if (done) begin
        n.rb = rb_val;
        n.rb_full = 1'b1;
        n.receive_irq_line = 1'b1;
        n.cnt = 5'h00;
        if (ren && r.rb_full && !rb_rd) begin
          n.re = 1'b1;
        end
        if (r.tb_full) begin
          // Back-to-back frames: no gap on the data line
          n.sr = ld_val;
          n.tx = hb ? ld_val[15] : ld_val[0];
          n.tb_full = tb_wr;
          n.transmit_irq_line = 1'b1;
        end else begin
          n.st = ssp_pkg::ST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= ssp_pkg::ST_IDLE;
      r.baud <= ssp_pkg::BAUD_RESET;
      {r.en, r.ms, r.cfg} <= ssp_pkg::CTRL_RESET[15:2];
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AWREADY = !r.aw_ok;
  assign WREADY = !r.w_ok;
  assign BVALID = r.bvalid;
  assign BRESP = r.bresp;
  assign ARREADY = !r.rvalid;
  assign RVALID = r.rvalid;
  assign RDATA = {16'h0000, r.rdata};
  assign RRESP = r.rresp;
  assign GENERATED_SHIFT_CLOCK = r.sclk;
  assign GENERATED_SHIFT_CLOCK_OE = r.en && r.ms;
  assign MASTER_OUT_SLAVE_IN_PIN_O = r.tx;
  assign MASTER_OUT_SLAVE_IN_PIN_OE = r.en && r.ms;
  assign MASTER_IN_SLAVE_OUT_PIN_O = r.tx;
  assign MASTER_IN_SLAVE_OUT_PIN_OE = r.en && !r.ms;
  assign TRANSMIT_IRQ_LINE = r.transmit_irq_line;
  assign RECEIVE_IRQ_LINE = r.receive_irq_line;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!rst_n);

  a_transmit_irq_line_at_start: assert property ($rose(busy) |-> r.transmit_irq_line)
    else $error("busy rose without transmit request");
  a_busy_end_receive_irq_line: assert property ($fell(busy) && r.en |-> r.receive_irq_line)
    else $error("busy cleared without receive buffer load");
  a_receive_irq_line_width: assert property (r.receive_irq_line |-> $past(cnt_n) == $past(w))
    else $error("receive request after wrong bit count");
  a_rx_overrun: assert property (done && proc && ren && r.rb_full && !rb_rd |=> r.re)
    else $error("unread buffer overrun not flagged");
  a_clk_idle: assert property (r.ms && r.st == ssp_pkg::ST_IDLE |-> r.sclk == po)
    else $error("master clock not at idle level");
  a_slave_no_clk: assert property (!r.ms |-> !GENERATED_SHIFT_CLOCK_OE)
    else $error("slave drives the clock pin");
  a_cfg_frozen: assert property (wr && r.aw_addr == ssp_pkg::OFS_CTRL && r.en |=> $stable(r.cfg))
    else $error("configuration changed while enabled");
  a_bc_steps: assert property (busy && $changed(r.cnt) |-> r.cnt == $past(r.cnt) + 5'h01 || r.cnt == 5'h00)
    else $error("bit counter jumped");
  a_te_cause: assert property ($rose(r.te) |-> $past(wr) || ($past(ten) && !$past(r.ms)))
    else $error("transmit error without slave start");
endmodule
`default_nettype wire

// ===== hdl/sync_stage2.sv
`timescale 1ns/1ps
`default_nettype none
module sync_stage2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels from outside, levels on clk
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_t;
  sync_t s_reg;
  sync_t s_next;

  always_comb begin
    s_next.meta = d;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.sync;
endmodule
`default_nettype wire

// ===== tb/spi_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  // Pins
  input wire logic sclk_in,
  input wire logic din,
  output logic sclk_out,
  output logic dout,
  // Frame setup
  input wire logic mst,
  input wire logic po,
  input wire logic ph,
  input wire logic hb,
  input wire logic [4:0] width,
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word
);
  int k = 16;
  initial begin
    sclk_out = 1'b0;
    dout = 1'b1;
    rx_word = '0;
  end
  function automatic int pos(int i);
    return hb ? int'(width) - 1 - i : i;
  endfunction
  task automatic arm();
    k = 0;
    rx_word = '0;
    sclk_out = po;
    if (ph) dout = tx_word[pos(0)];
  endtask
  task automatic edge_act(logic lead);
    if (lead ^ ph) begin
      if (k < width) dout = tx_word[pos(k)];
    end else begin
      rx_word[pos(k)] = din;
      k++;
      // Released line shows the inverse, never a held copy
      if (k == width) fork #20 dout = ~dout; join_none
    end
  endtask
  // Clock stands still outside frames
  task automatic run_master();
    repeat (width) begin
      #40 sclk_out = ~po;
      edge_act(1'b1);
      #40 sclk_out = po;
      edge_act(1'b0);
    end
  endtask
  always @(sclk_in) begin
    if (!mst && k < width) edge_act(sclk_in !== po);
  end
endmodule
`default_nettype wire

// ===== tb/tb_sync_serial_shift_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sync_serial_shift_engine;
  logic REF_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0] AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, gsc, gsc_oe;
  logic mosi_o, mosi_oe, miso_o, miso_oe, transmit_irq_line, receive_irq_line, p_sclk, p_dout;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic [31:0] seed = 32'h69FB7DE1;
  logic p_mst = 1'b0, p_po = 1'b0, p_ph = 1'b0, p_hb = 1'b0;
  logic [4:0] p_w = 5'h02;
  logic [15:0] p_tx = '0, p_rx;
  // Undriven data lines float high on their pull-ups
  wire logic sclk = gsc_oe ? gsc : p_sclk;
  wire logic mosi = mosi_oe ? mosi_o : (p_mst ? p_dout : 1'b1);
  wire logic miso = miso_oe ? miso_o : (p_mst ? 1'b1 : p_dout);
  int failures = 0, tests_run = 0, tx_irqs = 0, rx_irqs = 0;
  always #2 REF_CLK = ~REF_CLK;
  always @(negedge REF_CLK) begin
    if (transmit_irq_line === 1'b1) tx_irqs++;
    if (receive_irq_line === 1'b1) rx_irqs++;
  end
  sync_serial_shift_engine sync_serial_shift_engine_i (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'h3),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RECEIVED_SHIFT_CLOCK(sclk),
    .GENERATED_SHIFT_CLOCK(gsc), .GENERATED_SHIFT_CLOCK_OE(gsc_oe),
    .MASTER_OUT_SLAVE_IN_PIN_I(mosi), .MASTER_OUT_SLAVE_IN_PIN_O(mosi_o),
    .MASTER_OUT_SLAVE_IN_PIN_OE(mosi_oe), .MASTER_IN_SLAVE_OUT_PIN_I(miso),
    .MASTER_IN_SLAVE_OUT_PIN_O(miso_o), .MASTER_IN_SLAVE_OUT_PIN_OE(miso_oe),
    .TRANSMIT_IRQ_LINE(transmit_irq_line), .RECEIVE_IRQ_LINE(receive_irq_line));
  spi_far_end spi_far_end_i (
    .sclk_in(sclk), .din(p_mst ? miso : mosi), .sclk_out(p_sclk), .dout(p_dout),
    .mst(p_mst), .po(p_po), .ph(p_ph), .hb(p_hb), .width(p_w), .tx_word(p_tx),
    .rx_word(p_rx));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic ran_out(int n);
    if (n > 4000) begin
      failures++;
      $display("MISMATCH %0t wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    int n;
    logic aw_t, w_t, b_t;
    n = 0;
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= {16'h0000, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(negedge REF_CLK);
      aw_t = AWVALID && AWREADY === 1'b1;
      w_t = WVALID && WREADY === 1'b1;
      b_t = BVALID === 1'b1;
      @(posedge REF_CLK);
      if (aw_t) AWVALID <= 1'b0;
      if (w_t) WVALID <= 1'b0;
      ran_out(++n);
    end while (!b_t);
    BREADY <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_t, r_t;
    n = 0;
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(negedge REF_CLK);
      ar_t = ARVALID && ARREADY === 1'b1;
      r_t = RVALID === 1'b1;
      d = RDATA;
      r = RRESP;
      @(posedge REF_CLK);
      if (ar_t) ARVALID <= 1'b0;
      ran_out(++n);
    end while (!r_t);
    RREADY <= 1'b0;
  endtask
  task automatic rchk(logic [7:0] a, logic [31:0] m, logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d & m, exp);
  endtask
  task automatic wait_rx();
    int n;
    n = 0;
    do begin
      @(negedge REF_CLK);
      ran_out(++n);
    end while (receive_irq_line !== 1'b1);
    repeat (2) @(posedge REF_CLK);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i, w, t0, r0;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] m, tx;
    repeat (3) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    rchk(ssp_pkg::OFS_CTRL, 32'hFFFF, 32'h0000);
    rchk(ssp_pkg::OFS_BAUD, 32'hFFFF, 32'h0003);
    rd(8'h10, d, r);
    check(r, ssp_pkg::RESP_SLVERR);
    // Master frames over every phase and polarity, both orders, edge widths
    for (i = 0; i < 4; i++) begin
      w = (i == 0) ? 2 : (i == 1) ? 16 : (i == 2) ? 8 : 5;
      m = 16'hFFFF >> (16 - w);
      {p_ph, p_po} = 2'(i);
      p_hb = p_ph ^ p_po;
      p_w = 5'(w);
      p_mst = 1'b0;
      wr(ssp_pkg::OFS_CTRL, 16'h0000);
      wr(ssp_pkg::OFS_CTRL, {2'b11, 7'h00, p_po, p_ph, p_hb, 4'(w - 1)});
      rchk(ssp_pkg::OFS_CTRL, 32'hFFFF, 32'hC000);
      p_tx = rnd() & m;
      spi_far_end_i.arm();
      t0 = tx_irqs;
      r0 = rx_irqs;
      tx = rnd();
      wr(ssp_pkg::OFS_TB, tx);
      rchk(ssp_pkg::OFS_CTRL, 32'h1000, 32'h1000);
      wait_rx();
      check(tx_irqs - t0, 1);
      check(rx_irqs - r0, 1);
      rchk(ssp_pkg::OFS_RB, m, p_tx);
      check(p_rx & m, tx & m);
      rchk(ssp_pkg::OFS_CTRL, 32'hFFFF, 32'hC000);
    end
    // Slave frames on the outside clock, second one unloaded and unread
    p_mst = 1'b1;
    {p_po, p_ph, p_hb} = 3'b111;
    p_w = 5'd8;
    wr(ssp_pkg::OFS_CTRL, 16'h0000);
    wr(ssp_pkg::OFS_CTRL, 16'h8377);
    p_tx = rnd() & 16'h00FF;
    spi_far_end_i.arm();
    t0 = tx_irqs;
    tx = rnd();
    wr(ssp_pkg::OFS_TB, tx);
    repeat (8) @(posedge REF_CLK);
    #1.3;
    spi_far_end_i.run_master();
    wait_rx();
    check(p_rx & 16'h00FF, tx & 16'h00FF);
    check(tx_irqs - t0, 1);
    p_tx = rnd() & 16'h00FF;
    spi_far_end_i.arm();
    #1.3;
    spi_far_end_i.run_master();
    wait_rx();
    rchk(ssp_pkg::OFS_CTRL, 32'hFFFF, 32'h8300);
    rchk(ssp_pkg::OFS_RB, 32'h00FF, p_tx);
    wr(ssp_pkg::OFS_CTRL, 16'h8000);
    rchk(ssp_pkg::OFS_CTRL, 32'hFFFF, 32'h8000);
    stop_test();
  end
endmodule
`default_nettype wire
